/* e1rs_pkg.sv */
// constants shared by the e1 receive status page
package e1rs_pkg;

  // ---------------------------------------------------------------------
  // register map (byte addresses of the status page)
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_SYNC_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_RX_FRAME_ALIGN_SIGNAL       = 8'h11;
  localparam logic [7:0] ADDR_TIMER_STATUS = 8'h12;
  localparam logic [7:0] ADDR_RX_NONFRAME_ALIGN_SIGNAL      = 8'h13;
  localparam logic [7:0] ADDR_RX_MFAS      = 8'h14;
  localparam logic [7:0] READ_ZERO         = 8'h00;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int BIT_BASIC_LOSS = 7;
  localparam int BIT_MF_LOSS    = 6;
  localparam int BIT_CRC_LOSS   = 5;
  localparam int BIT_EBIT_FIRST = 4;
  localparam int BIT_EBIT_SEC   = 3;
  localparam int BIT_REFRAME    = 2;
  localparam int BIT_PERSIST    = 1;
  localparam int BIT_IWK        = 0;
  localparam int BIT_HALF_TOG   = 7;
  localparam int BIT_ONE_TOG    = 6;
  localparam int BIT_CRC_FLAG   = 5;
  localparam int BIT_EBIT_FLAG  = 4;
  localparam int BIT_LONG_TOG   = 3;
  localparam int BIT_SHORT_TOG  = 2;
  localparam int BIT_PHASE      = 1;
  localparam int BIT_TIMER_NONE = 0;
  localparam logic [7:0] FAS_GOOD_PATTERN = 8'h1b; // bits 2..8 = 0011011

  // ---------------------------------------------------------------------
  // timing, in milliseconds and in clock cycles
  // ---------------------------------------------------------------------
  localparam longint CLK_HZ        = 200000000;
  localparam longint MS_PER_SEC    = 1000;
  localparam longint CYCLES_PER_MS = CLK_HZ / MS_PER_SEC;
  localparam logic [9:0] SEC_MS        = 10'h3e8; // 1000 ms
  localparam logic [9:0] HALF_SEC_MS   = 10'h1f4; // 500 ms
  localparam logic [9:0] FLAG_HIGH_MS  = 10'h008; // 8 ms
  localparam logic [9:0] REFRAME_MS    = 10'h008; // 8 ms
  localparam logic [9:0] LONG_ALIGN_MS = 10'h190; // 400 ms
  localparam logic [9:0] PERSIST_MS    = 10'h008; // 8 ms
  localparam logic [9:0] PHASE_MS      = 10'h002; // 2 ms
  localparam logic [9:0] MS_ONE        = 10'h001;
  localparam logic [9:0] MS_ZERO       = 10'h000;

endpackage : e1rs_pkg

/* e1rs_status_page.sv */
// e1 receive status page: alignment state, captured bits and timers
`timescale 1ns/1ps

module e1rs_status_page
  import e1rs_pkg::*;
#(
  parameter longint CYCLES_MS = CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // alignment state from the receive framer
  input  wire logic       basic_frame_loss,
  input  wire logic       multiframe_loss,
  input  wire logic       crc4_multiframe_loss,
  input  wire logic       crc4_interworking,
  // captured overhead from the receive framer
  input  wire logic       fas_strobe,
  input  wire logic [7:0] fas_byte,
  input  wire logic       nfas_strobe,
  input  wire logic [7:0] nfas_byte,
  input  wire logic       ts16_strobe,
  input  wire logic [7:0] ts16_byte,
  input  wire logic       crc4_mf_strobe,
  input  wire logic       e_bit_first,
  input  wire logic       e_bit_second,
  // host access port
  input  wire logic       read_strobe,
  input  wire logic       write_strobe,
  input  wire logic [7:0] address,
  input  wire logic [7:0] write_data,
  output logic      [7:0] read_data,
  output logic            read_valid
);

  localparam int PRE_W = $clog2(CYCLES_MS);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_MS - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = '0;

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       sync_word;
    logic [7:0]       fas;
    logic [7:0]       nfas;
    logic [7:0]       mfas;
    logic             half_tog;
    logic             one_tog;
    logic             crc_flag;
    logic             ebit_flag;
    logic             long_tog;
    logic             short_tog;
    logic             phase;
    logic [PRE_W-1:0] pre;
    logic [9:0]       sec_ms;
    logic [9:0]       align_ms;
    logic [9:0]       persist_ms;
    logic [9:0]       phase_ms;
    logic [7:0]       rdata;
    logic             rvalid;
  } e1rs_state_t;

  e1rs_state_t st;
  e1rs_state_t next_st;
  logic        ms_tick;

  assign ms_tick = (st.pre == PRE_LAST);

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  // all timers share one millisecond prescaler, so their edges land on
  // common ticks; the persistence and reframe windows may therefore run
  // up to one millisecond short of the nominal figure
  always_comb begin
    logic [9:0] sec_inc;
    logic [9:0] align_inc;
    logic [9:0] persist_inc;
    logic [9:0] phase_inc;
    sec_inc     = st.sec_ms + MS_ONE;
    align_inc   = st.align_ms + MS_ONE;
    persist_inc = st.persist_ms + MS_ONE;
    phase_inc   = st.phase_ms + MS_ONE;
    next_st     = st;

    // free-running millisecond prescaler
    next_st.pre = ms_tick ? PRE_ZERO : st.pre + PRE_W'(1);

    // alignment state follows the framer
    next_st.sync_word[BIT_BASIC_LOSS] = basic_frame_loss;
    next_st.sync_word[BIT_MF_LOSS]    = multiframe_loss;
    next_st.sync_word[BIT_CRC_LOSS]   = crc4_multiframe_loss;
    next_st.sync_word[BIT_IWK]        = crc4_interworking;
    if (crc4_mf_strobe) begin
      next_st.sync_word[BIT_EBIT_FIRST] = e_bit_first;
      next_st.sync_word[BIT_EBIT_SEC]   = e_bit_second;
    end

    // overhead captures hold between strobes
    if (fas_strobe) begin
      next_st.fas = fas_byte;
    end
    if (nfas_strobe) begin
      next_st.nfas = nfas_byte;
    end
    if (ts16_strobe) begin
      next_st.mfas = ts16_byte;
    end

    // one-second frame: toggles and interval flags
    if (ms_tick) begin
      next_st.sec_ms = (sec_inc == SEC_MS) ? MS_ZERO : sec_inc;
      if (sec_inc == HALF_SEC_MS || sec_inc == SEC_MS) begin
        next_st.half_tog = ~st.half_tog;
      end
      if (sec_inc == SEC_MS) begin
        next_st.one_tog = ~st.one_tog;
      end
    end
    // flags high through the last 8 ms, falling as the interval starts
    next_st.crc_flag  = (next_st.sec_ms >= SEC_MS - FLAG_HIGH_MS);
    next_st.ebit_flag = (next_st.sec_ms >= SEC_MS - FLAG_HIGH_MS);

    // crc-4 alignment timers run only between basic sync and crc-4 sync
    if (st.sync_word[BIT_BASIC_LOSS] || !st.sync_word[BIT_CRC_LOSS]) begin
      next_st.align_ms = MS_ZERO;
    end else if (ms_tick) begin
      next_st.align_ms = (align_inc == LONG_ALIGN_MS) ? MS_ZERO : align_inc;
      if (align_inc == REFRAME_MS) begin
        next_st.short_tog = ~st.short_tog;
        next_st.sync_word[BIT_REFRAME] = 1'b1;
      end
      if (align_inc == LONG_ALIGN_MS) begin
        next_st.long_tog = ~st.long_tog;
      end
    end
    if (!st.sync_word[BIT_CRC_LOSS]) begin
      next_st.sync_word[BIT_REFRAME] = 1'b0;
    end

    // persistence: rises with loss, lingers after recovery
    if (st.sync_word[BIT_BASIC_LOSS]) begin
      next_st.sync_word[BIT_PERSIST] = 1'b1;
      next_st.persist_ms = MS_ZERO;
    end else if (st.sync_word[BIT_PERSIST] && ms_tick) begin
      next_st.persist_ms = persist_inc;
      if (persist_inc == PERSIST_MS) begin
        next_st.sync_word[BIT_PERSIST] = 1'b0;
      end
    end

    // alignment phase: free 2 ms toggle until aligned, then multiframe
    if (st.sync_word[BIT_CRC_LOSS]) begin
      if (ms_tick) begin
        next_st.phase_ms = (phase_inc == PHASE_MS) ? MS_ZERO : phase_inc;
        if (phase_inc == PHASE_MS) begin
          next_st.phase = ~st.phase;
        end
      end
    end else begin
      next_st.phase_ms = MS_ZERO;
      if (crc4_mf_strobe) begin
        next_st.phase = ~st.phase;
      end
    end

    // host reads; writes to this page change nothing
    next_st.rvalid = read_strobe;
    if (read_strobe) begin
      unique case (address)
        ADDR_SYNC_STATUS:  next_st.rdata = st.sync_word;
        ADDR_RX_FRAME_ALIGN_SIGNAL:       next_st.rdata = st.fas;
        ADDR_TIMER_STATUS: next_st.rdata = {st.half_tog, st.one_tog,
                                            st.crc_flag, st.ebit_flag,
                                            st.long_tog, st.short_tog,
                                            st.phase, 1'b0};
        ADDR_RX_NONFRAME_ALIGN_SIGNAL:      next_st.rdata = st.nfas;
        ADDR_RX_MFAS:      next_st.rdata = st.mfas;
        default:           next_st.rdata = READ_ZERO;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------------
  // loss bits come up set so software never sees a false "aligned"
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.sync_word <= 8'he2;
    end else begin
      st <= next_st;
    end
  end

  assign read_data  = st.rdata;
  assign read_valid = st.rvalid;

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_loss_follows_in: assert property (
    ##1 st.sync_word[BIT_BASIC_LOSS] == $past(basic_frame_loss))
    else $error("basic loss bit does not follow framer");
  a_persist_with_loss: assert property (
    st.sync_word[BIT_BASIC_LOSS] |=> st.sync_word[BIT_PERSIST])
    else $error("persistence not raised with loss");
  a_persist_fall_tick: assert property (
    $fell(st.sync_word[BIT_PERSIST]) |->
      $past(ms_tick) && !$past(st.sync_word[BIT_BASIC_LOSS]))
    else $error("persistence fell off a tick or during loss");
  a_fas_captured: assert property (
    fas_strobe |=> st.fas == $past(fas_byte))
    else $error("fas byte not captured");
  a_nfas_holds: assert property (
    !nfas_strobe |=> $stable(st.nfas))
    else $error("nfas changed without strobe");
  a_reframe_clears: assert property (
    !st.sync_word[BIT_CRC_LOSS] |=> !st.sync_word[BIT_REFRAME])
    else $error("reframe flag held with crc-4 sync");
  a_toggles_in_step: assert property (
    $changed(st.one_tog) |-> $changed(st.half_tog) && st.sec_ms == MS_ZERO)
    else $error("one-second toggle out of step");
  a_flag_fall_start: assert property (
    $fell(st.crc_flag) |-> st.sec_ms == MS_ZERO && !st.ebit_flag)
    else $error("interval flag fell off interval start");
  a_phase_aligned: assert property (
    !st.sync_word[BIT_CRC_LOSS] && !crc4_mf_strobe |=> $stable(st.phase))
    else $error("phase moved without multiframe");
  a_timer_bit_zero: assert property (
    read_strobe && address == ADDR_TIMER_STATUS |=>
      read_data[BIT_TIMER_NONE] == 1'b0 && read_valid)
    else $error("unused timer bit read as one");
  a_mfas_read: assert property (
    read_strobe && address == ADDR_RX_MFAS |=>
      read_data == $past(st.mfas))
    else $error("multiframe register read wrong");

  c_reframe_set:  cover property ($rose(st.sync_word[BIT_REFRAME]));
  c_persist_fall: cover property ($fell(st.sync_word[BIT_PERSIST]));
  c_phase_mf:     cover property (!st.sync_word[BIT_CRC_LOSS] ##1
                                  $changed(st.phase));
  c_long_toggle:  cover property ($changed(st.long_tog));

endmodule : e1rs_status_page

/* e1rs_framer_model.sv */
// far-end framer model: hands overhead bytes over as one-cycle strobes
`timescale 1ns/1ps

module e1rs_framer_model (
  // clock
  input  wire logic       ref_clk,
  // command from the bench
  input  wire logic       send,
  input  wire logic [1:0] kind,
  input  wire logic [7:0] value,
  // framer side of the status page
  output logic            fas_strobe,
  output logic      [7:0] fas_byte,
  output logic            nfas_strobe,
  output logic      [7:0] nfas_byte,
  output logic            ts16_strobe,
  output logic      [7:0] ts16_byte,
  output logic            crc4_mf_strobe,
  output logic            e_bit_first,
  output logic            e_bit_second
);
  // ---------------------------------------------------------------------
  // byte delivery
  // ---------------------------------------------------------------------
  // bytes flip between strobes so a late capture never sees a stale copy
  always_ff @(posedge ref_clk) begin
    fas_strobe     <= send && kind == 2'h0;
    nfas_strobe    <= send && kind == 2'h1;
    ts16_strobe    <= send && kind == 2'h2;
    crc4_mf_strobe <= send && kind == 2'h3;
    fas_byte       <= send ? value : ~fas_byte;
    nfas_byte      <= send ? value : ~nfas_byte;
    ts16_byte      <= send ? value : ~ts16_byte;
    if (send && kind == 2'h3) begin
      e_bit_first  <= value[1];
      e_bit_second <= value[0];
    end
  end
endmodule : e1rs_framer_model

/* e1_receive_status_page_tb_top.sv */
// self-checking bench for the e1 receive status page
`timescale 1ns/1ps

module e1_receive_status_page_tb_top
  import e1rs_pkg::*;
;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] mask;
    logic [7:0] exp;
  } e1rs_exp_t;

  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic       ref_clk = 1'b0, reset_n = 1'b0, send = 1'b0;
  logic       basic_frame_loss = 1'b1, multiframe_loss = 1'b1;
  logic       crc4_multiframe_loss = 1'b1, crc4_interworking = 1'b0;
  logic       read_strobe = 1'b0, write_strobe = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [7:0] value = 8'h00, address = 8'h00, write_data = 8'h00, v;
  logic [7:0] fas_byte, nfas_byte, ts16_byte, read_data;
  logic       fas_strobe, nfas_strobe, ts16_strobe, crc4_mf_strobe;
  logic       e_bit_first, e_bit_second, read_valid;
  integer     seed = 32'h2beefbe8;
  int         n_errors = 0, n_compared = 0;
  e1rs_exp_t  exp_q[$], cur;
  logic [7:0] tim_q[$];

  // small ms keeps the one-second timer checks short
  e1rs_status_page #(.CYCLES_MS(4)) u_dut (.ref_clk, .reset_n,
    .basic_frame_loss, .multiframe_loss, .crc4_multiframe_loss,
    .crc4_interworking, .fas_strobe, .fas_byte, .nfas_strobe, .nfas_byte,
    .ts16_strobe, .ts16_byte, .crc4_mf_strobe, .e_bit_first, .e_bit_second,
    .read_strobe, .write_strobe, .address, .write_data, .read_data,
    .read_valid);
  e1rs_framer_model u_far (.ref_clk, .send, .kind, .value, .fas_strobe,
    .fas_byte, .nfas_strobe, .nfas_byte, .ts16_strobe, .ts16_byte,
    .crc4_mf_strobe, .e_bit_first, .e_bit_second);

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // expectation is noted at the taking edge, the monitor pops it
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(posedge ref_clk);
    read_strobe <= 1'b1;
    address     <= a;
    exp_q.push_back('{a, m, e});
    @(posedge ref_clk);
    read_strobe <= 1'b0;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    write_strobe <= 1'b1;
    address      <= a;
    write_data   <= d;
    @(posedge ref_clk);
    write_strobe <= 1'b0;
  endtask : wr

  task automatic snd(input logic [1:0] k, input logic [7:0] d);
    @(posedge ref_clk);
    send  <= 1'b1;
    kind  <= k;
    value <= d;
    @(posedge ref_clk);
    send <= 1'b0;
    tick(2);
  endtask : snd

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------------
  // read monitor
  // ---------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (read_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unrequested read", 8'h00, 8'hff);
      end else begin
        cur = exp_q.pop_front();
        chk("read data", cur.exp, read_data & cur.mask);
        if (cur.addr == ADDR_TIMER_STATUS) begin
          tim_q.push_back(read_data);
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    tick(12);
    reset_n <= 1'b1;
    rd(ADDR_SYNC_STATUS, 8'hff, 8'he2);
    wr(ADDR_SYNC_STATUS, 8'h00);
    rd(ADDR_SYNC_STATUS, 8'hff, 8'he2);
    rd(8'h15, 8'hff, READ_ZERO);
    // last pass sends the correct alignment word over a random one
    for (int i = 0; i < 4; i++) begin
      v = (i == 3) ? FAS_GOOD_PATTERN : 8'($random(seed));
      address <= (i == 1) ? ADDR_RX_NONFRAME_ALIGN_SIGNAL : (i == 2) ? ADDR_RX_MFAS : ADDR_RX_FRAME_ALIGN_SIGNAL;
      snd((i == 3) ? 2'h0 : 2'(i), v);
      wr(address, ~v);
      rd(address, 8'hff, v);
    end
    snd(2'h3, 8'h02);
    basic_frame_loss  <= 1'b0;
    multiframe_loss   <= 1'b0;
    crc4_interworking <= 1'b1;
    tick(18);
    rd(ADDR_SYNC_STATUS, 8'hff, 8'h33);
    tick(25);
    rd(ADDR_SYNC_STATUS, 8'hff, 8'h35);
    crc4_multiframe_loss <= 1'b0;
    tick(3);
    rd(ADDR_SYNC_STATUS, 8'hff, 8'h11);
    // three timer reads exactly 500 ms apart
    for (int i = 0; i < 3; i++) begin
      rd(ADDR_TIMER_STATUS, 8'h01, 8'h00);
      tick(1998);
    end
    chk("half toggle", 8'h80, (tim_q[0] ^ tim_q[1]) & 8'h80);
    chk("half toggle", 8'h80, (tim_q[1] ^ tim_q[2]) & 8'h80);
    chk("second toggle", 8'h40, (tim_q[0] ^ tim_q[2]) & 8'h40);
    for (int i = 0; i < 3; i++) begin
      chk("interval flags", 8'(tim_q[i][5]), 8'(tim_q[i][4]));
    end
    chk("pending reads", 8'h00, 8'(exp_q.size()));
    finish_test();
  end
endmodule : e1_receive_status_page_tb_top
